// file: pkg/sem_regs.vh
// constants for the seat-end message handler
`ifndef SEM_REGS_VH
`define SEM_REGS_VH

// framing
`define SEM_PROTO            8'h01
`define SEM_CMD              8'hf4
`define SEM_LEN_SHORT        8'h03
`define SEM_LEN_ONE          8'h04
`define SEM_LEN_SEAT         8'h06
`define SEM_LEN_NAV          8'h21
`define SEM_SPACE            8'h20

// sub-command codes
`define SEM_DISPLAY_OFF_CODE 24'h545658
`define SEM_VOLUME_UP_CODE   24'h564f55
`define SEM_VOLUME_DOWN_CODE 24'h564f44
`define SEM_PLAY_PAUSE_CODE  24'h505054
`define SEM_CHANNEL_UP_CODE  24'h434855
`define SEM_CHANNEL_DOWN_CODE 24'h434644
`define SEM_ATTN_CALL_CODE   24'h464143
`define SEM_ATTN_CANCEL_CODE 24'h464343
`define SEM_NAV_INFO_CODE    24'h414e4a
`define SEM_ALL_ON_CODE      24'h414c4f
`define SEM_ALL_OFF_CODE     24'h414c58
`define SEM_SYS_MODE_CODE    24'h49534d
`define SEM_SEAT_QUERY_CODE  24'h534e52
`define SEM_SEAT_ANSWER_CODE 24'h534e53
`define SEM_SMOKE_CODE       24'h534d44

// system modes, remaining-time limit and smoke white light level
`define SEM_MODE_IDLE        3'h0
`define SEM_MODE_DECOMPRESSION_MODE      3'h3
`define SEM_MODE_UNKNOWN     3'h4
`define SEM_REMAIN_MAX       32'h00000800
`define SEM_LIGHT_WHITE      8'hff

// timing
`define SEM_REPEAT_MS        100
`define SEM_CLK_PERIOD_NS    5
`define SEM_REPEAT_CYCLES    ((`SEM_REPEAT_MS * 1000000) / `SEM_CLK_PERIOD_NS)

// register offsets and fields
`define SEM_CTRL             12'h000
`define SEM_STATUS           12'h004
`define SEM_SEAT             12'h008
`define SEM_VOLUME           12'h00c
`define SEM_REMAIN           12'h010
`define SEM_NAV_COUNT        12'h014
`define SEM_DROP_COUNT       12'h018
`define SEM_NAV_BASE         12'h100
`define SEM_NAV_BYTES        6'h1e
`define SEM_CTRL_QUERY       0
`define SEM_CTRL_LEVEL_LSB   8
`define SEM_RESET_LEVEL      8'h80

`endif

// file: design/sem_nav_mem.v
// byte store for the navigation frame payload
`timescale 1ns/10ps
module sem_nav_mem #(
   parameter AW = 6,
   parameter DW = 8
) (
   // clock
   input  wire          pclk,
   // write side
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   // read side
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule

// file: design/sem_handler.v
// seat-end message encoder and decoder with apb registers
`timescale 1ns/10ps
`include "sem_regs.vh"
module sem_handler #(
   parameter REPEAT_CYCLES = `SEM_REPEAT_CYCLES,
   parameter [7:0] VOL_MAX = 8'h0f
) (
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // passenger buttons, high while pressed
   input  wire        btn_display_off,
   input  wire        btn_blackout,
   input  wire        btn_all_off,
   input  wire        btn_all_on,
   input  wire        btn_volume_up,
   input  wire        btn_volume_down,
   input  wire        btn_play_pause,
   input  wire        btn_channel_up,
   input  wire        btn_channel_down,
   // outgoing byte stream
   output reg         tx_valid,
   output reg  [7:0]  tx_data,
   output reg         tx_last,
   input  wire        tx_ready,
   // incoming byte stream
   input  wire        rx_valid,
   input  wire [7:0]  rx_data,
   input  wire        rx_last,
   // seat outputs
   output reg         attendant_lamp,
   output reg         backlight_on,
   output reg         smoke_active,
   output reg  [7:0]  light_level,
   output reg  [2:0]  system_mode
);

   localparam K_DOFF = 0;
   localparam K_VUP  = 1;
   localparam K_VDN  = 2;
   localparam K_PPT  = 3;
   localparam K_CHU  = 4;
   localparam K_CHD  = 5;
   localparam K_ALO  = 6;
   localparam K_ALX  = 7;
   localparam K_SNR  = 8;
   localparam NK     = 9;

   ////////////////////////////////////////////////////////////////////////////
   // buttons and message requests

   wire [8:0] btn = {btn_channel_down, btn_channel_up, btn_play_pause,
                     btn_volume_down, btn_volume_up, btn_all_on,
                     btn_all_off, btn_blackout, btn_display_off};
   reg  [8:0] btn_q;
   wire [8:0] press = btn & ~btn_q;
   wire [1:0] rep_fire;
   wire       query_wr;
   wire [NK-1:0] ev;
   reg  [NK-1:0] pend;
   wire [NK-1:0] sent;

   // edges only, so a held key asks once; held volume keys also repeat via rep_fire
   assign ev[K_DOFF] = press[0] | press[1] | press[2];
   assign ev[K_VUP]  = press[4] | rep_fire[0];
   assign ev[K_VDN]  = press[5] | rep_fire[1];
   assign ev[K_PPT]  = press[6];
   assign ev[K_CHU]  = press[7];
   assign ev[K_CHD]  = press[8];
   assign ev[K_ALO]  = press[3];
   assign ev[K_ALX]  = press[2];
   assign ev[K_SNR]  = query_wr;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         btn_q <= 9'h000;
         pend  <= 9'h000;
      end else begin
         btn_q <= btn;
         // a new request wins over the launch that clears it
         pend  <= (pend & ~sent) | ev;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : rep
         reg [31:0] cnt;
         wire held = btn[4+g] & btn_q[4+g];
         assign rep_fire[g] = held && (cnt == REPEAT_CYCLES - 1);
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt <= 32'h00000000;
            end else if (!held || rep_fire[g]) begin
               cnt <= 32'h00000000;
            end else begin
               cnt <= cnt + 32'h00000001;
            end
         end
      end
   endgenerate

   // volume level kept here, clamped at both ends
   reg [7:0] volume;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         volume <= 8'h00;
      end else if (ev[K_VUP] && !ev[K_VDN] && volume != VOL_MAX) begin
         volume <= volume + 8'h01;
      end else if (ev[K_VDN] && !ev[K_VUP] && volume != 8'h00) begin
         volume <= volume - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit serialiser

   function [3:0] pick;
      input [NK-1:0] p;
      integer i;
      begin
         pick = 4'h0;
         for (i = NK - 1; i >= 0; i = i - 1) begin
            if (p[i]) begin
               pick = i[3:0];
            end
         end
      end
   endfunction

   function [23:0] code_of;
      input [3:0] k;
      begin
         case (k)
            4'h1: code_of = `SEM_VOLUME_UP_CODE;
            4'h2: code_of = `SEM_VOLUME_DOWN_CODE;
            4'h3: code_of = `SEM_PLAY_PAUSE_CODE;
            4'h4: code_of = `SEM_CHANNEL_UP_CODE;
            4'h5: code_of = `SEM_CHANNEL_DOWN_CODE;
            4'h6: code_of = `SEM_ALL_ON_CODE;
            4'h7: code_of = `SEM_ALL_OFF_CODE;
            4'h8: code_of = `SEM_SEAT_QUERY_CODE;
            default: code_of = `SEM_DISPLAY_OFF_CODE;
         endcase
      end
   endfunction

   reg  [2:0]  tx_idx;
   reg  [23:0] tx_code;
   wire [2:0]  next_tx_idx = tx_idx + 3'h1;
   wire [3:0]  tx_pick = pick(pend);
   wire        launch = !tx_valid && (|pend);
   reg  [7:0]  next_tx_data;

   assign sent = launch ? ({{(NK-1){1'b0}}, 1'b1} << tx_pick) : {NK{1'b0}};

   always @* begin
      case (next_tx_idx)
         3'h1: next_tx_data = `SEM_CMD;
         3'h2: next_tx_data = `SEM_LEN_SHORT;
         3'h3: next_tx_data = tx_code[23:16];
         3'h4: next_tx_data = tx_code[15:8];
         3'h5: next_tx_data = tx_code[7:0];
         default: next_tx_data = `SEM_PROTO;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_valid <= 1'b0;
         tx_data  <= 8'h00;
         tx_last  <= 1'b0;
         tx_idx   <= 3'h0;
         tx_code  <= 24'h000000;
      end else if (launch) begin
         tx_valid <= 1'b1;
         tx_data  <= `SEM_PROTO;
         tx_last  <= 1'b0;
         tx_idx   <= 3'h0;
         tx_code  <= code_of(tx_pick);
      end else if (tx_valid && tx_ready) begin
         if (tx_last) begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
         end else begin
            tx_idx  <= next_tx_idx;
            tx_data <= next_tx_data;
            tx_last <= (next_tx_idx == 3'h5);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive parser

   reg  [5:0]  rx_idx;
   reg         rx_bad;
   reg         rx_bcd_bad;
   reg  [7:0]  rx_len;
   reg  [23:0] rx_code;
   reg  [7:0]  rx_p0;
   reg  [23:0] rx_seat;
   reg  [31:0] rx_remain;
   reg  [5:0]  rx_total;
   reg         rx_done;
   wire        digit_bad = (rx_data[3:0] > 4'h9) || (rx_data[7:4] > 4'h9);
   wire        mem_we = rx_valid && rx_idx >= 6'h06 && rx_idx < 6'h24;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_idx     <= 6'h00;
         rx_bad     <= 1'b0;
         rx_bcd_bad <= 1'b0;
         rx_len     <= 8'h00;
         rx_code    <= 24'h000000;
         rx_p0      <= 8'h00;
         rx_seat    <= 24'h000000;
         rx_remain  <= 32'h00000000;
         rx_total   <= 6'h00;
         rx_done    <= 1'b0;
      end else begin
         rx_done <= rx_valid && rx_last;
         if (rx_valid) begin
            if (rx_last) begin
               rx_idx   <= 6'h00;
               rx_total <= rx_idx + 6'h01;
            end else if (rx_idx != 6'h3f) begin
               rx_idx <= rx_idx + 6'h01;
            end
            if (rx_idx == 6'h00) begin
               rx_bad     <= (rx_data != `SEM_PROTO);
               rx_bcd_bad <= 1'b0;
            end else if ((rx_idx == 6'h01 && rx_data != `SEM_CMD) || rx_idx == 6'h3f) begin
               rx_bad <= 1'b1;
            end
            if (rx_idx == 6'h02) begin
               rx_len <= rx_data;
            end
            if (rx_idx >= 6'h03 && rx_idx <= 6'h05) begin
               rx_code <= {rx_code[15:0], rx_data};
            end
            if (rx_idx == 6'h06) begin
               rx_p0 <= rx_data;
            end
            if (rx_idx >= 6'h06 && rx_idx <= 6'h08) begin
               rx_seat <= {rx_seat[15:0], rx_data};
            end
            // both 3-byte times sit at payload bytes 20 to 25
            if (rx_idx >= 6'h1a && rx_idx <= 6'h1f && digit_bad) begin
               rx_bcd_bad <= 1'b1;
            end
            if (rx_idx >= 6'h20 && rx_idx <= 6'h23) begin
               rx_remain <= {rx_remain[23:0], rx_data};
            end
         end
      end
   end

   // decode one cycle after the last byte
   wire frame_ok = rx_done && !rx_bad && rx_total >= 6'h06 &&
                   ({2'b00, rx_total} - 8'h03) == rx_len;
   wire short_ok = frame_ok && rx_len == `SEM_LEN_SHORT;
   wire one_ok   = frame_ok && rx_len == `SEM_LEN_ONE;
   wire got_call   = short_ok && rx_code == `SEM_ATTN_CALL_CODE;
   wire got_cancel = short_ok && rx_code == `SEM_ATTN_CANCEL_CODE;
   wire got_all_on = short_ok && rx_code == `SEM_ALL_ON_CODE;
   wire got_all_off = short_ok && rx_code == `SEM_ALL_OFF_CODE;
   wire got_mode  = one_ok && rx_code == `SEM_SYS_MODE_CODE &&
                    rx_p0 <= {5'h00, `SEM_MODE_UNKNOWN};
   wire got_smoke = one_ok && rx_code == `SEM_SMOKE_CODE && rx_p0 <= 8'h01;
   wire got_seat  = frame_ok && rx_len == `SEM_LEN_SEAT &&
                    rx_code == `SEM_SEAT_ANSWER_CODE;
   wire got_nav   = frame_ok && rx_len == `SEM_LEN_NAV &&
                    rx_code == `SEM_NAV_INFO_CODE && !rx_bcd_bad &&
                    rx_remain <= `SEM_REMAIN_MAX;
   wire got_any   = got_call | got_cancel | got_all_on | got_all_off |
                    got_mode | got_smoke | got_seat | got_nav;

   ////////////////////////////////////////////////////////////////////////////
   // seat state

   reg [7:0]  pass_level;
   reg [23:0] seat_number;
   reg [15:0] remain_min;
   reg        nav_valid;
   reg [15:0] nav_count;
   reg [15:0] drop_count;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         attendant_lamp <= 1'b0;
         backlight_on   <= 1'b1;
         smoke_active   <= 1'b0;
         light_level    <= `SEM_RESET_LEVEL;
         system_mode    <= `SEM_MODE_UNKNOWN;
         seat_number    <= 24'h000000;
         remain_min     <= 16'h0000;
         nav_valid      <= 1'b0;
         nav_count      <= 16'h0000;
         drop_count     <= 16'h0000;
      end else begin
         if (got_call) begin
            attendant_lamp <= 1'b1;
         end else if (got_cancel) begin
            attendant_lamp <= 1'b0;
         end
         if (got_all_on) begin
            backlight_on <= 1'b1;
         end else if (got_all_off) begin
            backlight_on <= 1'b0;
         end
         if (got_smoke) begin
            smoke_active <= rx_p0[0];
         end
         // white overrides; passenger level returns once smoke clears
         light_level <= smoke_active ? `SEM_LIGHT_WHITE : pass_level;
         if (got_mode) begin
            system_mode <= rx_p0[2:0];
         end
         if (got_seat) begin
            seat_number <= rx_seat;
         end
         if (got_nav) begin
            remain_min <= rx_remain[15:0];
            nav_valid  <= 1'b1;
            nav_count  <= nav_count + 16'h0001;
         end
         if (rx_done && !got_any) begin
            drop_count <= drop_count + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, one wait state on every access

   wire        acc = psel && penable && !pready;
   wire        wr  = psel && penable && pready && pwrite;
   // a literal cannot be part-selected, so the base goes through a named constant
   localparam [11:0] NAV_BASE = `SEM_NAV_BASE;
   wire        in_nav = paddr[11:8] == NAV_BASE[11:8] &&
                        paddr[7:2] < `SEM_NAV_BYTES;
   wire [7:0]  nav_rdata;
   reg  [31:0] rd_word;
   reg         mapped;

   assign query_wr = wr && paddr == `SEM_CTRL && pwdata[`SEM_CTRL_QUERY];

   sem_nav_mem #(
      .AW (6),
      .DW (8)
   ) u_nav_mem (
      .pclk  (pclk),
      .we    (mem_we),
      .waddr (rx_idx - 6'h06),
      .wdata (rx_data),
      .raddr (paddr[7:2]),
      .rdata (nav_rdata)
   );

   always @* begin
      rd_word = 32'h00000000;
      mapped  = 1'b1;
      if (paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
      end else if (in_nav) begin
         rd_word = {24'h000000, nav_rdata};
      end else begin
         case (paddr)
            `SEM_CTRL:       rd_word = {16'h0000, pass_level, 8'h00};
            `SEM_STATUS:     rd_word = {24'h000000, tx_valid, nav_valid, system_mode,
                                        smoke_active, backlight_on, attendant_lamp};
            `SEM_SEAT:       rd_word = {8'h00, seat_number};
            `SEM_VOLUME:     rd_word = {24'h000000, volume};
            `SEM_REMAIN:     rd_word = {16'h0000, remain_min};
            `SEM_NAV_COUNT:  rd_word = {16'h0000, nav_count};
            `SEM_DROP_COUNT: rd_word = {16'h0000, drop_count};
            default:         mapped  = 1'b0;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h00000000;
         pass_level <= `SEM_RESET_LEVEL;
      end else begin
         pready  <= acc;
         pslverr <= acc && !mapped;
         if (acc && !pwrite) begin
            prdata <= mapped ? rd_word : 32'h00000000;
         end
         if (wr && paddr == `SEM_CTRL) begin
            pass_level <= pwdata[`SEM_CTRL_LEVEL_LSB +: 8];
         end
      end
   end

endmodule

// file: tb/sem_handler_sva.sv
// concurrent checks on the seat-end message handler ports
`timescale 1ns/10ps
module sem_handler_sva (
   // clock, reset, button
   input wire       pclk,
   input wire       presetn,
   input wire       btn_display_off,
   // byte streams
   input wire       tx_valid,
   input wire [7:0] tx_data,
   input wire       tx_last,
   input wire       tx_ready,
   input wire       rx_valid,
   input wire [7:0] rx_data,
   input wire       rx_last,
   // seat outputs
   input wire       attendant_lamp,
   input wire       backlight_on,
   input wire       smoke_active,
   input wire [7:0] light_level,
   input wire [2:0] system_mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////////
   reg [2:0]  tn;
   reg [5:0]  rn;
   reg [47:0] sh;
   // byte positions, cleared by each last byte so a bad frame cannot skew the next
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tn <= 3'h0;
         rn <= 6'h0;
         sh <= 48'h0;
      end else begin
         if (tx_valid && tx_ready)
            tn <= tx_last ? 3'h0 : tn + 3'h1;
         if (rx_valid) begin
            rn <= rx_last ? 6'h0 : rn + 6'h1;
            sh <= {sh[39:0], rx_data};
         end
      end
   end
   sequence s_end6(logic [23:0] c);
      rx_valid && rx_last && rn == 6'h5 && {sh[39:0], rx_data} == {24'h01f403, c};
   endsequence
   sequence s_end7(logic [23:0] c);
      rx_valid && rx_last && rn == 6'h6 && sh == {24'h01f404, c};
   endsequence
   ////////////////////////////////////////////////////////////////////////////////////
   property p_head; $rose(tx_valid) |-> tx_data == 8'h01 && tn == 3'h0; endproperty
   a_head: assert property (p_head) else $error("frame start wrong");
   property p_last; tx_valid && tx_last |-> tn == 3'h5; endproperty
   a_last: assert property (p_last) else $error("last flag misplaced");
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tn);
   endproperty
   a_hold: assert property (p_hold) else $error("offered byte changed");
   property p_tvoff; $rose(btn_display_off) |-> ##[1:400] $rose(tx_valid); endproperty
   a_tvoff: assert property (p_tvoff) else $error("no message after press");
   property p_lamp_on; s_end6(24'h464143) |-> ##2 attendant_lamp; endproperty
   a_lamp_on: assert property (p_lamp_on) else $error("lamp not on");
   property p_lamp_off; s_end6(24'h464343) |-> ##2 !attendant_lamp; endproperty
   a_lamp_off: assert property (p_lamp_off) else $error("lamp not off");
   property p_dark; s_end6(24'h414c58) |-> ##2 !backlight_on; endproperty
   a_dark: assert property (p_dark) else $error("backlight not off");
   property p_mode;
      s_end7(24'h49534d) ##0 rx_data < 8'h05 |-> ##2 system_mode == $past(rx_data[2:0], 2);
   endproperty
   a_mode: assert property (p_mode) else $error("mode not taken");
   property p_white;
      s_end7(24'h534d44) ##0 rx_data == 8'h01 |-> ##2 smoke_active ##1 light_level == 8'hff;
   endproperty
   a_white: assert property (p_white) else $error("no white light");
   property p_drop;
      rx_valid && rx_last && rn == 6'h5 && sh[39:32] != 8'h01
         |=> $stable({attendant_lamp, backlight_on, system_mode})[*3];
   endproperty
   a_drop: assert property (p_drop) else $error("bad frame changed outputs");
endmodule

// file: tb/sem_mgmt_node.sv
// management node model: stalling byte sink and frame source
`timescale 1ns/10ps
module sem_mgmt_node #(
   parameter [23:0] SEAT_NO = 24'h123456
) (
   // clock and stall control
   input  wire        pclk,
   input  wire        slow,
   // seat to node
   input  wire        tx_valid,
   input  wire [7:0]  tx_data,
   input  wire        tx_last,
   output logic       tx_ready = 1'b0,
   // node to seat
   output logic       rx_valid = 1'b0,
   output logic [7:0] rx_data = 8'h00,
   output logic       rx_last = 1'b0
);
   logic [47:0] cur;
   logic [47:0] got[$];
   logic [1:0]  ph = 2'h0;
   logic        bl_on = 1'b1;
   logic        playing = 1'b0;
   int          nreq = 0;
   int          nans = 0;
   // slow mode takes one byte in four
   always @(posedge pclk) begin
      ph <= ph + 2'h1;
      tx_ready <= !slow || ph == 2'h0;
      if (tx_valid && tx_ready) begin
         cur <= {cur[39:0], tx_data};
         if (tx_last) begin
            got.push_back({cur[39:0], tx_data});
            case ({cur[15:0], tx_data})
               24'h545658, 24'h414c58: bl_on <= 1'b0;
               24'h414c4f: bl_on <= 1'b1;
               24'h505054: playing <= !playing;
               24'h534e52: nreq <= nreq + 1;
               default: ;
            endcase
         end
      end
   end
   task automatic send(input logic [7:0] f[$]);
      foreach (f[i]) begin
         @(posedge pclk);
         rx_valid <= 1'b1;
         rx_data <= f[i];
         rx_last <= (i == f.size() - 1);
      end
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      // released line must not keep showing the last byte
      rx_data <= ~f[f.size() - 1];
   endtask
   initial begin
      forever begin
         @(posedge pclk);
         if (nreq != nans) begin
            nans++;
            send({8'h01, 8'hf4, 8'h06, 8'h53, 8'h4e, 8'h53, SEAT_NO[23:16], SEAT_NO[15:8],
                  SEAT_NO[7:0]});
         end
      end
   end
endmodule

// file: tb/sem_handler_test.sv
// self-checking bench for the seat-end message handler
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module sem_handler_test;
   logic        pclk, pready, pslverr, tx_valid, tx_last, tx_ready, rx_valid, rx_last, rerr;
   logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic        attendant_lamp, backlight_on, smoke_active;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0]  tx_data, rx_data, light_level;
   logic [2:0]  system_mode;
   logic [8:0]  btn = 9'h000;
   logic [47:0] g;
   int          err_count = 0, comparisons = 0, k;
   logic [23:0] codes [9] = '{24'h545658, 24'h545658, 24'h545658, 24'h414c4f, 24'h564f55,
                              24'h564f44, 24'h505054, 24'h434855, 24'h434644};
   sem_handler #(.REPEAT_CYCLES(50)) sem_handler_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .btn_display_off(btn[0]), .btn_blackout(btn[1]), .btn_all_off(btn[2]),
      .btn_all_on(btn[3]), .btn_volume_up(btn[4]), .btn_volume_down(btn[5]),
      .btn_play_pause(btn[6]), .btn_channel_up(btn[7]), .btn_channel_down(btn[8]),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .attendant_lamp(attendant_lamp), .backlight_on(backlight_on),
      .smoke_active(smoke_active), .light_level(light_level), .system_mode(system_mode));
   sem_mgmt_node sem_mgmt_node_inst (
      .pclk(pclk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));
   ////////////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      if (err_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task hang;
      err_count++;
      $display("MISMATCH %0t timeout", $time);
      end_of_test;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         hang;
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task msg(input logic [23:0] c);
      int n;
      for (n = 0; n < 2000 && sem_mgmt_node_inst.got.size() == 0; n++)
         @(posedge pclk);
      if (sem_mgmt_node_inst.got.size() == 0)
         hang;
      g = sem_mgmt_node_inst.got.pop_front();
      `CHK(g, {24'h01f403, c})
   endtask
   task press(input int b, input int hold);
      btn[b] <= 1'b1;
      repeat (hold) @(posedge pclk);
      btn[b] <= 1'b0;
      repeat (20) @(posedge pclk);
   endtask
   task vol(input int b, input int hold, input int n, input logic [31:0] lvl);
      press(b, hold);
      repeat (40) @(posedge pclk);
      if (n > 0)
         `CHK(sem_mgmt_node_inst.got.size(), n)
      sem_mgmt_node_inst.got.delete();
      rchk(12'h00c, lvl);
   endtask
   task rx(input logic [23:0] c, input int a);
      if (a < 0)
         sem_mgmt_node_inst.send({8'h01, 8'hf4, 8'h03, c[23:16], c[15:8], c[7:0]});
      else
         sem_mgmt_node_inst.send({8'h01, 8'hf4, 8'h04, c[23:16], c[15:8], c[7:0], a[7:0]});
      repeat (5) @(posedge pclk);
   endtask
   task nav(input logic [31:0] rem, input logic [7:0] hr);
      logic [7:0] f[$];
      f = {8'h01, 8'hf4, 8'h21, 8'h41, 8'h4e, 8'h4a};
      for (int i = 0; i < 20; i++)
         f.push_back(i < 10 ? 8'h30 + i[7:0] : (i < 12 ? 8'h20 : 8'h4b));
      f = {f, hr, 8'h34, 8'h56, 8'h23, 8'h59, 8'h01,
           rem[31:24], rem[23:16], rem[15:8], rem[7:0]};
      sem_mgmt_node_inst.send(f);
      repeat (5) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(12'h004, 32'h22);
      rchk(12'h000, 32'h8000);
      apb(1'b0, 12'h020, 32'h0);
      `CHK(rerr, 1'b1)
      // one-shot buttons held well past the repeat period, sink stalling
      slow <= 1'b1;
      for (k = 0; k < 9; k++) begin
         if (k == 4 || k == 5)
            continue;
         press(k, 200);
         msg(codes[k]);
         if (k == 2)
            msg(24'h414c58);
         if (k < 3)
            `CHK(sem_mgmt_node_inst.bl_on, 1'b0)
         `CHK(sem_mgmt_node_inst.got.size(), 0)
      end
      `CHK(sem_mgmt_node_inst.playing, 1'b1)
      `CHK(sem_mgmt_node_inst.bl_on, 1'b1)
      slow <= 1'b0;
      vol(5, 900, 0, 32'h0);
      vol(4, 125, 3, 32'h3);
      vol(5, 125, 3, 32'h0);
      vol(4, 900, 0, 32'hf);
      rx(24'h464143, -1);
      `CHK(attendant_lamp, 1'b1)
      sem_mgmt_node_inst.send({8'h02, 8'hf4, 8'h03, 8'h46, 8'h43, 8'h43});
      repeat (5) @(posedge pclk);
      `CHK(attendant_lamp, 1'b1)
      rx(24'h464343, -1);
      `CHK(attendant_lamp, 1'b0)
      rx(24'h414c58, -1);
      `CHK(backlight_on, 1'b0)
      rx(24'h414c4f, -1);
      `CHK(backlight_on, 1'b1)
      for (k = 0; k < 6; k++) begin
         rx(24'h49534d, k);
         `CHK(system_mode, (k < 5) ? k[2:0] : 3'h4)
      end
      apb(1'b1, 12'h000, 32'h3c00);
      rx(24'h534d44, 1);
      `CHK(light_level, 8'hff)
      rx(24'h534d44, 0);
      `CHK(light_level, 8'h3c)
      rchk(12'h018, 32'h2);
      apb(1'b1, 12'h000, 32'h3c01);
      msg(24'h534e52);
      repeat (30) @(posedge pclk);
      rchk(12'h008, 32'h123456);
      rchk(12'h000, 32'h3c00);
      nav(32'h800, 8'h12);
      rchk(12'h010, 32'h800);
      rchk(12'h014, 32'h1);
      rchk(12'h004, 32'h62);
      rchk(12'h128, 32'h20);
      rchk(12'h150, 32'h12);
      nav(32'h801, 8'h12);
      nav(32'h10, 8'h1a);
      rchk(12'h010, 32'h800);
      rchk(12'h018, 32'h4);
      end_of_test;
   end
endmodule
bind sem_handler sem_handler_sva sem_handler_sva_inst (
   .pclk(pclk), .presetn(presetn), .btn_display_off(btn_display_off), .tx_valid(tx_valid),
   .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
   .rx_data(rx_data), .rx_last(rx_last), .attendant_lamp(attendant_lamp),
   .backlight_on(backlight_on), .smoke_active(smoke_active), .light_level(light_level),
   .system_mode(system_mode));
